// ### core/bpd_core.sv
`timescale 1ns/1ps
module bpd_core
    import bpd_pkg::*;
(
    input  wire logic                     clock_in,
    input  wire logic                     rst_in,
    input  wire logic [7:0]               reg_addr_in,
    input  wire logic [7:0]               reg_wdata_in,
    input  wire logic                     reg_wr_in,
    input  wire logic                     reg_rd_in,
    output logic      [7:0]               reg_rdata_out,
    input  wire logic                     chip_ctrl_up_inhibit_in,
    input  wire logic [6:0]               port_decode_enable_in,
    input  wire logic [BPD_IO_ADDR_W-1:0] io_addr_in,
    input  wire logic                     io_window_hit_in,
    output logic                          io_claim_out,
    input  wire logic                     txn_start_in,
    input  wire logic                     txn_write_in,
    input  wire logic                     txn_upstream_in,
    input  wire logic                     txn_prefetch_in,
    input  wire logic                     txn_multi_read_in,
    input  wire logic                     buf_empty_in,
    input  wire logic                     src_valid_in,
    input  wire logic                     src_last_in,
    input  wire logic                     tgt_accept_in,
    output logic                          txn_busy_out,
    output logic                          posted_out,
    output logic                          dn_burst_out,
    output logic                          up_multi_out,
    output logic                          src_take_out,
    output logic                          fwd_valid_out,
    output logic                          src_release_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    bpd_regs_t                  cur_ff;
    bpd_regs_t                  nxt_cur;
    logic [BPD_NUM_RANGES-1:0]  range_hit;

    // ------------------------------------------------------------------
    // Legacy range match
    // ------------------------------------------------------------------
    // One comparator pair per map bit; a range matches when the address
    // bits above its mask equal its base.
    genvar gi;
    generate
        for (gi = 0; gi < BPD_NUM_RANGES; gi = gi + 1) begin : g_range
            assign range_hit[gi] =
                ((io_addr_in & ~BPD_RANGE_MASK_A[gi]) == BPD_RANGE_BASE_A[gi]) ||
                ((io_addr_in & ~BPD_RANGE_MASK_B[gi]) == BPD_RANGE_BASE_B[gi]);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Register access, primary decode and the write sequencer all live in
    // one process so that every output is a plain flop of the carrier.
    always_comb begin
        logic       en_range;
        logic       map_says;
        logic       post_sel;
        nxt_cur  = cur_ff;
        en_range = 1'b0;
        map_says = 1'b0;
        post_sel = 1'b0;

        // Register writes keep only writable bits, so reserved bits stay
        // zero and no write to them has any effect.
        if (reg_wr_in) begin
            if (reg_addr_in == BPD_OFS_POST_CTRL) begin
                nxt_cur.post_ctrl = reg_wdata_in & BPD_WMASK_POST;  // see (R01) (R02) (R22)
            end else if (reg_addr_in == BPD_OFS_PORT_MAP) begin
                nxt_cur.port_map = reg_wdata_in & BPD_WMASK_MAP;    // see (R18) (R22)
            end
        end

        // Read data stands for exactly the cycle after the read strobe.
        nxt_cur.rdata = BPD_RD_UNMAPPED;
        if (reg_rd_in) begin
            if (reg_addr_in == BPD_OFS_POST_CTRL) begin
                nxt_cur.rdata = cur_ff.post_ctrl & BPD_WMASK_POST;  // see (R01) (R02)
            end else if (reg_addr_in == BPD_OFS_PORT_MAP) begin
                nxt_cur.rdata = cur_ff.port_map & BPD_WMASK_MAP;    // see (R18)
            end
        end

        // Primary decode: a legacy range only overrides the I/O window
        // when its decode enable is set; then the map bit alone decides.
        en_range = |(range_hit & port_decode_enable_in);           // see (R21)
        map_says = |(range_hit & port_decode_enable_in & cur_ff.port_map[6:0]);
        if (en_range) begin
            nxt_cur.claim = map_says;  // see (R10) (R11) (R12) (R13) (R14) (R15) (R16) (R17)
        end else begin
            nxt_cur.claim = io_window_hit_in;
        end

        // Pulses default low every cycle.
        nxt_cur.take        = 1'b0;
        nxt_cur.release_src = 1'b0;

        // Upstream traffic touches the primary side, downstream the
        // secondary side; each direction has its own posting enable.
        post_sel = txn_upstream_in ? cur_ff.post_ctrl[BPD_BIT_POST_PRI]
                                   : cur_ff.post_ctrl[BPD_BIT_POST_SEC];

        unique case (cur_ff.state)
            BPD_ST_IDLE: begin
                // Controls are sampled only here, so a register change made
                // mid-transfer waits for the next accepted transaction.
                if (txn_start_in) begin                             // see (R22)
                    nxt_cur.dn_burst = !txn_upstream_in && !txn_write_in &&
                                       txn_prefetch_in &&
                                       cur_ff.post_ctrl[BPD_BIT_DN_BURST];  // see (R05)
                    nxt_cur.up_multi = txn_upstream_in && !txn_write_in &&
                                       txn_multi_read_in &&
                                       cur_ff.post_ctrl[BPD_BIT_UP_MULTI] &&
                                       !chip_ctrl_up_inhibit_in;    // see (R03) (R04)
                    if (txn_write_in) begin
                        nxt_cur.posted = post_sel;
                        if (post_sel) begin
                            nxt_cur.state = BPD_ST_POSTED;
                        end else begin
                            nxt_cur.state = BPD_ST_DRAIN;           // see (R06) (R07)
                        end
                    end else begin
                        nxt_cur.posted = 1'b0;
                    end
                end
            end
            BPD_ST_DRAIN: begin
                // Buffered data must be gone before unposted data enters.
                if (buf_empty_in) begin
                    nxt_cur.state = BPD_ST_FETCH;                   // see (R06) (R07)
                end
            end
            BPD_ST_FETCH: begin
                // Take one word, then hold off the source.
                if (src_valid_in) begin
                    nxt_cur.take      = 1'b1;
                    nxt_cur.fwd_valid = 1'b1;
                    nxt_cur.last      = src_last_in;
                    nxt_cur.state     = BPD_ST_FORWARD;             // see (R08)
                end
            end
            BPD_ST_FORWARD: begin
                // The next word is only taken after the target accepts,
                // and the master is released only after the last one.
                if (tgt_accept_in) begin
                    nxt_cur.fwd_valid = 1'b0;
                    if (cur_ff.last) begin
                        nxt_cur.release_src = 1'b1;                 // see (R09)
                        nxt_cur.state       = BPD_ST_IDLE;
                    end else begin
                        nxt_cur.state = BPD_ST_FETCH;               // see (R08)
                    end
                end
            end
            BPD_ST_POSTED: begin
                // Posted words stream in; the master completes with the last.
                // The source drops its offer only after it sees the registered
                // take, so the cycle right after a take is skipped; otherwise
                // the same word would be counted twice.
                if (src_valid_in && !cur_ff.take) begin
                    nxt_cur.take = 1'b1;
                    if (src_last_in) begin
                        nxt_cur.release_src = 1'b1;
                        nxt_cur.state       = BPD_ST_IDLE;
                    end
                end
            end
        endcase

        // Busy is a flop of its own so the output needs no decode.
        nxt_cur.busy = (nxt_cur.state != BPD_ST_IDLE);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Synchronous reset to the documented register defaults.
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cur_ff.post_ctrl   <= BPD_RST_POST_CTRL;               // see (R19)
            cur_ff.port_map    <= BPD_RST_PORT_MAP;                // see (R20)
            cur_ff.rdata       <= BPD_RD_UNMAPPED;
            cur_ff.state       <= BPD_ST_IDLE;
            cur_ff.claim       <= 1'b0;
            cur_ff.posted      <= 1'b0;
            cur_ff.dn_burst    <= 1'b0;
            cur_ff.up_multi    <= 1'b0;
            cur_ff.take        <= 1'b0;
            cur_ff.fwd_valid   <= 1'b0;
            cur_ff.release_src <= 1'b0;
            cur_ff.busy        <= 1'b0;
            cur_ff.last        <= 1'b0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Every output is a direct flop of the state carrier.
    assign reg_rdata_out   = cur_ff.rdata;
    assign io_claim_out    = cur_ff.claim;
    assign txn_busy_out    = cur_ff.busy;
    assign posted_out      = cur_ff.posted;
    assign dn_burst_out    = cur_ff.dn_burst;
    assign up_multi_out    = cur_ff.up_multi;
    assign src_take_out    = cur_ff.take;
    assign fwd_valid_out   = cur_ff.fwd_valid;
    assign src_release_out = cur_ff.release_src;

endmodule

// ### core/bpd_pkg.sv
// Function
// (R01) Posting control bits 7..5 read zero
// (R02) Posting control bit 3 reads zero
// (R03) Upstream bit 4 selects multi-line read bursts
// (R04) Multi-line bursting only while chip-control bit clear
// (R05) Bit 2 enables downstream prefetchable read bursts
// (R06) Bit 1 clear: drain, no posting upstream
// (R07) Bit 0 clear: drain, no posting downstream
// (R08) Unposted: target accepts word before next
// (R09) Unposted: release master after last accepted
// (R10) Map clear: never claim range on primary
// (R11) Map bit 0 governs serial range one
// (R12) Map bit 1 governs serial range two
// (R13) Map bit 2 governs serial range three
// (R14) Map bit 3 governs serial range four
// (R15) Map bit 4 governs parallel range one
// (R16) Map bit 5 governs parallel range two
// (R17) Map bit 6 governs parallel range three
// (R18) Map register bit 7 reads zero
// (R19) Posting control resets to 07h
// (R20) Map register resets to 00h
// (R21) Map applies only where decode enable set
// (R22) Reserved writes ignored; changes apply next transaction
package bpd_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] BPD_OFS_POST_CTRL = 8'h59;
    localparam logic [7:0] BPD_OFS_PORT_MAP  = 8'h5A;
    localparam logic [7:0] BPD_RST_POST_CTRL = 8'h07;
    localparam logic [7:0] BPD_RST_PORT_MAP  = 8'h00;
    localparam logic [7:0] BPD_WMASK_POST    = 8'h17;
    localparam logic [7:0] BPD_WMASK_MAP     = 8'h7F;
    localparam logic [7:0] BPD_RD_UNMAPPED   = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BPD_BIT_POST_SEC   = 0;
    localparam int BPD_BIT_POST_PRI   = 1;
    localparam int BPD_BIT_DN_BURST   = 2;
    localparam int BPD_BIT_UP_MULTI   = 4;
    localparam int BPD_NUM_RANGES     = 7;
    localparam int BPD_IO_ADDR_W      = 16;

    // ------------------------------------------------------------------
    // Legacy port ranges: two base/mask pairs per map bit.
    // Serial ranges repeat their single window in both slots.
    // ------------------------------------------------------------------
    localparam logic [6:0][15:0] BPD_RANGE_BASE_A = {
        16'h0278, 16'h0378, 16'h03BC, 16'h02E8, 16'h03E8, 16'h02F8, 16'h03F8};
    localparam logic [6:0][15:0] BPD_RANGE_MASK_A = {
        16'h0007, 16'h0007, 16'h0003, 16'h0007, 16'h0007, 16'h0007, 16'h0007};
    localparam logic [6:0][15:0] BPD_RANGE_BASE_B = {
        16'h0678, 16'h0778, 16'h07BC, 16'h02E8, 16'h03E8, 16'h02F8, 16'h03F8};
    localparam logic [6:0][15:0] BPD_RANGE_MASK_B = {
        16'h0003, 16'h0003, 16'h0003, 16'h0007, 16'h0007, 16'h0007, 16'h0007};

    // ------------------------------------------------------------------
    // Write transfer sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        BPD_ST_IDLE    = 5'b00001,
        BPD_ST_DRAIN   = 5'b00010,
        BPD_ST_FETCH   = 5'b00100,
        BPD_ST_FORWARD = 5'b01000,
        BPD_ST_POSTED  = 5'b10000
    } bpd_state_t;

    // Whole block state in one carrier.
    typedef struct packed {
        logic [7:0] post_ctrl;
        logic [7:0] port_map;
        logic [7:0] rdata;
        bpd_state_t state;
        logic       claim;
        logic       posted;
        logic       dn_burst;
        logic       up_multi;
        logic       take;
        logic       fwd_valid;
        logic       release_src;
        logic       busy;
        logic       last;
    } bpd_regs_t;

endpackage

// ### testbench/bpd_far_model.sv
`timescale 1ns/1ps
module bpd_far_model (
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    input  wire logic       load_in,
    input  wire logic [3:0] words_in,
    input  wire logic       slow_in,
    input  wire logic       take_in,
    input  wire logic       fwd_in,
    output logic            valid_out,
    output logic            last_out,
    output logic            accept_out
);
    logic [3:0] left_ff;
    logic       wait_ff;
    // Source holds each word until it is taken; a slow target waits one cycle.
    always_ff @(posedge clock_in) begin
        if (rst_in || load_in) begin
            left_ff <= rst_in ? 4'h0 : words_in;
        end else if (take_in) begin
            left_ff <= left_ff - 4'h1;
        end
        wait_ff    <= fwd_in && !accept_out && !wait_ff && !rst_in;
        accept_out <= fwd_in && !accept_out && (!slow_in || wait_ff) && !rst_in;
    end
    // The final word is flagged so the bridge knows when to let go.
    assign valid_out = left_ff != 4'h0;
    assign last_out  = left_ff == 4'h1;
endmodule

// ### testbench/bpd_properties.sv
`timescale 1ns/1ps
module bpd_properties (
    input wire logic        clock_in,
    input wire logic        rst_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        chip_ctrl_up_inhibit_in,
    input wire logic [6:0]  port_decode_enable_in,
    input wire logic [15:0] io_addr_in,
    input wire logic        io_window_hit_in,
    input wire logic        io_claim_out,
    input wire logic        txn_start_in,
    input wire logic        txn_write_in,
    input wire logic        txn_upstream_in,
    input wire logic        txn_prefetch_in,
    input wire logic        txn_multi_read_in,
    input wire logic        buf_empty_in,
    input wire logic        tgt_accept_in,
    input wire logic        txn_busy_out,
    input wire logic        posted_out,
    input wire logic        dn_burst_out,
    input wire logic        up_multi_out,
    input wire logic        src_take_out,
    input wire logic        fwd_valid_out,
    input wire logic        src_release_out
);
    // ------
    // Shadow registers and expected per-transaction flags
    // ------
    logic [7:0] post_ff, map_ff;
    logic       go, dn_exp, up_exp, pst_exp;
    // Shadow copies, masked the way software must see them.
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            post_ff <= 8'h07;
            map_ff  <= 8'h00;
        end else if (reg_wr_in && reg_addr_in == 8'h59) begin
            post_ff <= reg_wdata_in & 8'h17;
        end else if (reg_wr_in && reg_addr_in == 8'h5A) begin
            map_ff <= reg_wdata_in & 8'h7F;
        end
    end
    // Controls are sampled when an idle block accepts a transaction.
    assign go      = txn_start_in && !txn_busy_out;
    assign dn_exp  = !txn_write_in && !txn_upstream_in && txn_prefetch_in && post_ff[2];
    assign up_exp  = !txn_write_in && txn_upstream_in && txn_multi_read_in && post_ff[4]
                     && !chip_ctrl_up_inhibit_in;
    assign pst_exp = txn_upstream_in ? post_ff[1] : post_ff[0];
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    sequence rd_of(a); reg_rd_in && reg_addr_in == a; endsequence
    sequence held_word; fwd_valid_out && !tgt_accept_in; endsequence
    sequence unposted_go; go && txn_write_in && !pst_exp; endsequence
    post_read_a: assert property (
        rd_of(8'h59) |=> reg_rdata_out == $past(post_ff))
        else $error("posting control read wrong");
    map_read_a: assert property (
        rd_of(8'h5A) |=> reg_rdata_out == $past(map_ff))
        else $error("port map read wrong");
    rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data outside its cycle");
    dn_burst_a: assert property (go |=> dn_burst_out == $past(dn_exp))
        else $error("downstream burst flag wrong");
    up_multi_a: assert property (go |=> up_multi_out == $past(up_exp))
        else $error("upstream multi-line flag wrong");
    posting_sel_a: assert property (
        go && txn_write_in |=> posted_out == $past(pst_exp))
        else $error("posting choice wrong");
    write_busy_a: assert property (go && txn_write_in |=> txn_busy_out)
        else $error("write not accepted");
    drain_wait_a: assert property (
        unposted_go ##1 !buf_empty_in |=> !src_take_out && !fwd_valid_out)
        else $error("word taken before buffers drained");
    word_hold_a: assert property (held_word |=> !src_take_out)
        else $error("word taken before target accepted");
    release_gate_a: assert property (
        src_release_out && !posted_out |-> $past(tgt_accept_in))
        else $error("master released early");
    map_gate_a: assert property (
        io_addr_in[15:3] == 13'h007F && port_decode_enable_in[0]
        |=> io_claim_out == $past(map_ff[0]))
        else $error("serial range one claim wrong");
    window_fallback_a: assert property (
        port_decode_enable_in == 7'h00 |=> io_claim_out == $past(io_window_hit_in))
        else $error("window claim wrong");
endmodule
bind bpd_core bpd_properties u_props (
    .clock_in                (clock_in),
    .rst_in                  (rst_in),
    .reg_wr_in               (reg_wr_in),
    .reg_rd_in               (reg_rd_in),
    .reg_addr_in             (reg_addr_in),
    .reg_wdata_in            (reg_wdata_in),
    .reg_rdata_out           (reg_rdata_out),
    .chip_ctrl_up_inhibit_in (chip_ctrl_up_inhibit_in),
    .port_decode_enable_in   (port_decode_enable_in),
    .io_addr_in              (io_addr_in),
    .io_window_hit_in        (io_window_hit_in),
    .io_claim_out            (io_claim_out),
    .txn_start_in            (txn_start_in),
    .txn_write_in            (txn_write_in),
    .txn_upstream_in         (txn_upstream_in),
    .txn_prefetch_in         (txn_prefetch_in),
    .txn_multi_read_in       (txn_multi_read_in),
    .buf_empty_in            (buf_empty_in),
    .tgt_accept_in           (tgt_accept_in),
    .txn_busy_out            (txn_busy_out),
    .posted_out              (posted_out),
    .dn_burst_out            (dn_burst_out),
    .up_multi_out            (up_multi_out),
    .src_take_out            (src_take_out),
    .fwd_valid_out           (fwd_valid_out),
    .src_release_out         (src_release_out)
);

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
    logic clock_in = 1'b0, rst_in = 1'b1, rw, rr, inh, win, st, wr, up, pf, mr, be, ld, slow;
    logic vld, lst, acc, claim, busy, posted, dnb, upm, take, fwd, rel;
    logic [7:0] addr, wd, rdata;
    logic [6:0] en;
    logic [15:0] ioa;
    logic [3:0] words;
    int err_total = 0, checked = 0, cycles = 0;
    // ------
    // Design, far side and clock
    // ------
    bpd_core dut (.clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_wr_in(rw), .reg_rd_in(rr), .reg_rdata_out(rdata),
        .chip_ctrl_up_inhibit_in(inh), .port_decode_enable_in(en), .io_addr_in(ioa),
        .io_window_hit_in(win), .io_claim_out(claim), .txn_start_in(st), .txn_write_in(wr),
        .txn_upstream_in(up), .txn_prefetch_in(pf), .txn_multi_read_in(mr),
        .buf_empty_in(be), .src_valid_in(vld), .src_last_in(lst), .tgt_accept_in(acc),
        .txn_busy_out(busy), .posted_out(posted), .dn_burst_out(dnb), .up_multi_out(upm),
        .src_take_out(take), .fwd_valid_out(fwd), .src_release_out(rel));
    bpd_far_model far (.clock_in(clock_in), .rst_in(rst_in), .load_in(ld), .words_in(words),
        .slow_in(slow), .take_in(take), .fwd_in(fwd), .valid_out(vld), .last_out(lst),
        .accept_out(acc));
    always #10 clock_in = ~clock_in;
    // A hung handshake is cut short at cycle 3000, long after the run should end.
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("mismatches=%0d comparisons=%0d", err_total, checked);
        if (err_total == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Inputs move just after an edge so nothing races the design's sampling.
    task automatic tick();
        @(posedge clock_in);
        #1;
    endtask
    // A spare edge after each strobe keeps the next call from driving the
    // same strobe twice in one time step.
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wd <= d;
        rw <= 1'b1;
        tick();
        rw <= 1'b0;
        tick();
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        addr <= a;
        rr <= 1'b1;
        tick();
        rr <= 1'b0;
        check(rdata, exp);
        tick();
    endtask
    task automatic txn(input logic w, input logic u, input logic p, input logic m,
                       input logic [3:0] n, input logic s);
        {wr, up, pf, mr, words, slow} <= {w, u, p, m, n, s};
        st <= 1'b1;
        ld <= w;
        tick();
        st <= 1'b0;
        ld <= 1'b0;
    endtask
    // Waits for the release pulse, counting words taken, then one spare cycle.
    task automatic wait_rel(output int takes);
        takes = 0;
        for (int i = 0; i < 60 && rel !== 1'b1; i++) begin
            tick();
            if (take === 1'b1)
                takes++;
        end
        check(rel, 1'b1);
        tick();
    endtask
    // ------
    // Scenarios
    // ------
    task automatic t_regs();
        rreg(8'h59, 8'h07);
        rreg(8'h5A, 8'h00);
        wreg(8'h59, 8'hFF);
        rreg(8'h59, 8'h17);
        wreg(8'h5A, 8'hFF);
        rreg(8'h5A, 8'h7F);
        wreg(8'h33, 8'hFF);
        rreg(8'h33, 8'h00);
        wreg(8'h59, 8'h07);
    endtask
    task automatic t_decode();
        logic [15:0] tbl [7] = '{16'h03F8, 16'h02F8, 16'h03E8, 16'h02EF, 16'h07BC,
                                 16'h077B, 16'h0678};
        en <= 7'h7F;
        win <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            wreg(8'h5A, 8'h00);
            ioa <= tbl[i];
            tick();
            check(claim, 1'b0);
            wreg(8'h5A, 8'h01 << i);
            tick();
            check(claim, 1'b1);
        end
        en <= 7'h00;
        tick();
        tick();
        check(claim, 1'b1);
    endtask
    // One read transaction; both burst flags are judged while they stand,
    // then an edge passes so the next start is a fresh assignment.
    task automatic rd_txn(input logic u, input logic p, input logic m,
                          input logic [1:0] exp);
        txn(1'b0, u, p, m, 4'h0, 1'b0);
        check({dnb, upm}, exp);
        tick();
    endtask
    task automatic t_burst();
        rd_txn(0, 1, 0, 2'b10);
        rd_txn(1, 0, 1, 2'b00);
        wreg(8'h59, 8'h13);
        rd_txn(1, 0, 1, 2'b01);
        rd_txn(0, 1, 0, 2'b00);
        inh <= 1'b1;
        rd_txn(1, 0, 1, 2'b00);
        inh <= 1'b0;
    endtask
    task automatic t_writes();
        int n;
        wreg(8'h59, 8'h04);
        for (int u = 0; u < 2; u++) begin
            be <= 1'b0;
            txn(1, u[0], 0, 0, 4'h2, !u[0]);
            repeat (4) tick();
            check({busy, take, fwd}, 3'b100);
            be <= 1'b1;
            wait_rel(n);
            check(n, 2);
            check({busy, posted}, 2'b00);
        end
        wreg(8'h59, 8'h07);
        txn(1, 1, 0, 0, 4'h3, 0);
        wait_rel(n);
        check(n, 3);
        check({busy, posted}, 2'b01);
        txn(1, 0, 0, 0, 4'h1, 0);
        wait_rel(n);
        check(n, 1);
        check({busy, posted}, 2'b01);
    endtask
    initial begin
        {rw, rr, inh, win, st, wr, up, pf, mr, ld, slow} = '0;
        {be, addr, wd, en, ioa, words} = {1'b1, 8'h00, 8'h00, 7'h00, 16'h0000, 4'h0};
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        tick();
        t_regs();
        t_decode();
        t_burst();
        t_writes();
        wrap_up();
    end
endmodule
